/* rtl/tma_map.svh */
`ifndef TMA_MAP_SVH
`define TMA_MAP_SVH

// register indices on the plain register port
`define TMA_ADDR_W 3
`define TMA_DATA_W 16
`define TMA_REG_TEMP 3'h0
`define TMA_REG_CONF 3'h1
`define TMA_REG_HYST 3'h2
`define TMA_REG_TOS 3'h3
`define TMA_REG_STAT 3'h4
`define TMA_REG_MASK 3'h5
`define TMA_REG_ADDR 3'h6

// temperature word layout: 9-bit two's complement in bits 15..7
`define TMA_TEMP_W 9
`define TMA_TEMP_LSB 7

// configuration fields
`define TMA_CONF_W 5
`define TMA_CONF_SHUT 0
`define TMA_CONF_INT 1
`define TMA_CONF_POL 2
`define TMA_CONF_FQ_LO 3
`define TMA_CONF_RST 5'h00

// reset thresholds in 0.5 degree steps: 80 C and 75 C
`define TMA_TOS_RST 9'h0a0
`define TMA_HYST_RST 9'h096

// interrupt status bits
`define TMA_IRQ_W 2
`define TMA_IRQ_CONV 0
`define TMA_IRQ_ALERT 1

// target address: fixed upper nibble, straps below
`define TMA_TADDR_HI 4'h9

// conversion period
`define TMA_CONV_MS 100
`define TMA_CLK_KHZ 100000
`define TMA_CONV_CYCLES (`TMA_CONV_MS * `TMA_CLK_KHZ)
`define TMA_CNT_W 24

`endif

/* rtl/tma_pkg.sv */
package tma_pkg;

  typedef enum logic [1:0] {
    TMA_CV_RUN = 2'b00,
    TMA_CV_SHUT = 2'b01,
    TMA_CV_WAIT = 2'b10
  } tma_cv_t;

  typedef struct packed {
    tma_cv_t cv;
    logic [23:0] cnt;
    logic [8:0] temp;
    logic [8:0] tos;
    logic [8:0] hyst;
    logic [4:0] conf;
    logic [2:0] faults;
    logic alert;
    logic look_low;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [15:0] rdata;
    logic irq;
    logic od_oe_b;
    logic [6:0] taddr;
    logic [1:0] strap_done;
    logic [8:0] adc_prev;
    logic [8:0] adc_hold;
  } tma_state_t;

endpackage

/* rtl/tma_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for pins from outside the clock domain
module tma_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tma_sync_t;

  tma_sync_t st_r;
  tma_sync_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

`default_nettype wire

/* rtl/tma_top.sv */
// Contract
// - conversion yields a 9-bit result for the register port and comparator
// - stored result refreshes once per conversion, period 100 ms
// - temperature readable any time, returning the last completed result
// - a read aborts a running conversion, restarting it after the read
// - alert goes active when temperature rises above alarm threshold
// - alert has comparator and latched interrupt behaviours
// - host writes both thresholds and reads back stored values
// - reset gives comparator mode, alarm 80 C, release 75 C
// - three straps give the low address bits, eight devices per bus
// - alert needs 1, 2, 4 or 6 consecutive over-limit conversions
// - results compared against both setpoint and hysteresis value
// - mode and active polarity programmable, pin follows polarity
// - values are 9-bit two's complement, one step 0.5 C
// - target address is 1001 followed by the three strap bits
// - comparator alert holds until temperature drops below release
// - interrupt alert latches until any read, then rearms on release
`timescale 1ns/1ps
`default_nettype none
`include "tma_map.svh"

module tma_top
  import tma_pkg::*;
#(
  parameter int CONV_CYCLES = `TMA_CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`TMA_ADDR_W-1:0] reg_addr,
  input wire logic [`TMA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`TMA_DATA_W-1:0] reg_rdata,
  input wire logic [`TMA_TEMP_W-1:0] adc_sample,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  output logic [6:0] target_addr,
  output logic alert_od_out,
  output logic alert_od_oe_b,
  output logic irq
);

  localparam logic [23:0] CONV_LAST = 24'(CONV_CYCLES - 1);

  // behaviour notes for whoever touches this block next:
  // - the conversion time base counts clk_sys cycles; a result is taken
  //   only when the count runs out with no read and no shutdown pending
  // - any read strobe aborts the running conversion and the count starts
  //   over in the cycle after the strobe, so a host that polls faster
  //   than one conversion period never sees a fresh result
  // - the comparator looks at the held sample, not the raw pins, so a
  //   sample that changes in the last cycles of a conversion is missed
  // - the fault counter only moves when a conversion completes; writes
  //   to the thresholds take effect at the next completed conversion
  // - in comparator mode the same fault count is needed to release the
  //   alert as to raise it, which slows the release on purpose
  // - in interrupt mode the latch is cleared by any read or shutdown,
  //   and the direction it looks for flips after every trip
  // - a mode change keeps the alert and the fault count as they are
  // - straps are caught once, three edges after reset; moving them later
  //   has no effect until the next reset
  // - the status bits are sticky and a read of the status index clears
  //   them, but an event in that same cycle still sets its bit
  // - the level interrupt output follows status and mask from the same
  //   edge, so it drops in the cycle after the clearing read
  // - reads of the sample index return the last completed result with
  //   the seven low bits zero
  // - shutdown halts the count; the last result and the thresholds stay
  //   readable and writable
  // - the open-drain pin is only ever pulled low; its high level comes
  //   from the board, so the data output is tied low and the enable
  //   alone carries the alert

  tma_state_t st_r;
  tma_state_t st_nxt;
  logic [`TMA_TEMP_W-1:0] adc_s;
  logic [2:0] strap_s;

  // analog result and straps come from outside the clock domain
  tma_sync #(
    .W(`TMA_TEMP_W)
  ) u_adc_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(adc_sample),
    .q(adc_s)
  );

  tma_sync #(
    .W(3)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
    .q(strap_s)
  );

  // fault queue depth from the two config bits
  // coding 11 asks for six faults, the longest run supported
  function automatic logic [2:0] fq_need(input logic [1:0] sel);
    case (sel)
      2'b00: fq_need = 3'h1;
      2'b01: fq_need = 3'h2;
      2'b10: fq_need = 3'h4;
      default: fq_need = 3'h6;
    endcase
  endfunction

  logic conv_end;
  logic over;
  logic under;
  logic cond;
  logic trip;
  logic [2:0] need;
  logic [2:0] faults_inc;
  logic shut;
  logic int_mode;
  logic alert_rise;
  logic [8:0] new_temp;

  // conversion end and comparator terms
  always_comb begin
    shut = st_r.conf[`TMA_CONF_SHUT];
    int_mode = st_r.conf[`TMA_CONF_INT];
    // a read or a shutdown in the last count cycle aborts the result
    conv_end = (st_r.cv == TMA_CV_RUN) && (st_r.cnt == CONV_LAST)
      && !reg_rd && !shut;
    // only a sample word that held still for two cycles is used
    new_temp = st_r.adc_hold;
    over = $signed(new_temp) > $signed(st_r.tos);
    under = $signed(new_temp) < $signed(st_r.hyst);
    if (int_mode) begin
      cond = st_r.look_low ? under : over;
    end else begin
      cond = st_r.alert ? under : over;
    end
    need = fq_need(st_r.conf[`TMA_CONF_FQ_LO +: 2]);
    faults_inc = st_r.faults + 3'h1;
    trip = conv_end && cond && (faults_inc >= need);
  end

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    alert_rise = 1'b0;

    // straps need two edges through the synchroniser before they are
    // valid, so the address is caught on the third edge after reset
    if (st_r.strap_done != 2'h3) begin
      st_nxt.strap_done = st_r.strap_done + 2'h1;
    end
    if (st_r.strap_done == 2'h2) begin
      st_nxt.taddr = {`TMA_TADDR_HI, strap_s};
    end

    // the sample pins are synced bit by bit, so a word caught while
    // the pins change may be torn; accept it only once it repeats
    st_nxt.adc_prev = adc_s;
    if (adc_s == st_r.adc_prev) begin
      st_nxt.adc_hold = adc_s;
    end

    // conversion time base: run, wait out a read, or stand still in
    // shutdown; the count restarts from zero on every way back to run
    case (st_r.cv)
      TMA_CV_RUN: begin
        if (shut) begin
          st_nxt.cv = TMA_CV_SHUT;
          st_nxt.cnt = '0;
        end else if (reg_rd) begin
          st_nxt.cv = TMA_CV_WAIT;
          st_nxt.cnt = '0;
        end else if (conv_end) begin
          st_nxt.cnt = '0;
          st_nxt.temp = new_temp;
        end else begin
          st_nxt.cnt = st_r.cnt + 24'h1;
        end
      end
      TMA_CV_WAIT: begin
        // restart only once the read is over
        if (shut) begin
          st_nxt.cv = TMA_CV_SHUT;
        end else if (!reg_rd) begin
          st_nxt.cv = TMA_CV_RUN;
        end
        st_nxt.cnt = '0;
      end
      TMA_CV_SHUT: begin
        st_nxt.cnt = '0;
        if (!shut) begin
          st_nxt.cv = TMA_CV_RUN;
        end
      end
      default: begin
        st_nxt.cv = TMA_CV_RUN;
        st_nxt.cnt = '0;
      end
    endcase

    // consecutive fault count, evaluated at conversion end only
    // the count clears after a trip so the next change needs a full run
    if (conv_end) begin
      if (trip) begin
        st_nxt.faults = '0;
      end else if (cond) begin
        st_nxt.faults = faults_inc;
      end else begin
        st_nxt.faults = '0;
      end
    end

    // alert state
    // comparator mode toggles on each trip, interrupt mode sets the latch
    // and flips the direction it waits for
    if (trip) begin
      if (int_mode) begin
        st_nxt.alert = 1'b1;
        st_nxt.look_low = !st_r.look_low;
        alert_rise = !st_r.alert;
      end else begin
        st_nxt.alert = !st_r.alert;
        alert_rise = !st_r.alert;
      end
    end
    // interrupt mode: any read or shutdown releases the latch
    if (int_mode && (reg_rd || shut)) begin
      st_nxt.alert = 1'b0;
    end

    // register writes
    // read-only and unused indices are ignored without any sign
    if (reg_wr) begin
      case (reg_addr)
        `TMA_REG_CONF: begin
          st_nxt.conf = reg_wdata[`TMA_CONF_W-1:0];
        end
        `TMA_REG_HYST: begin
          st_nxt.hyst = reg_wdata[`TMA_TEMP_LSB +: `TMA_TEMP_W];
        end
        `TMA_REG_TOS: begin
          st_nxt.tos = reg_wdata[`TMA_TEMP_LSB +: `TMA_TEMP_W];
        end
        `TMA_REG_MASK: begin
          st_nxt.mask = reg_wdata[`TMA_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, data stands in the next cycle only
    // unused indices and idle cycles read as zero
    st_nxt.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `TMA_REG_TEMP: begin
          st_nxt.rdata = {st_r.temp, 7'h00};
        end
        `TMA_REG_CONF: begin
          st_nxt.rdata = {11'h000, st_r.conf};
        end
        `TMA_REG_HYST: begin
          st_nxt.rdata = {st_r.hyst, 7'h00};
        end
        `TMA_REG_TOS: begin
          st_nxt.rdata = {st_r.tos, 7'h00};
        end
        `TMA_REG_STAT: begin
          st_nxt.rdata = {14'h0000, st_r.stat};
        end
        `TMA_REG_MASK: begin
          st_nxt.rdata = {14'h0000, st_r.mask};
        end
        `TMA_REG_ADDR: begin
          st_nxt.rdata = {9'h000, st_r.taddr};
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // sticky status: read clears, a new event in the same cycle wins
    // the mask only gates the level output, never the sticky bits
    if (reg_rd && (reg_addr == `TMA_REG_STAT)) begin
      st_nxt.stat = '0;
    end
    if (conv_end) begin
      st_nxt.stat[`TMA_IRQ_CONV] = 1'b1;
    end
    if (alert_rise) begin
      st_nxt.stat[`TMA_IRQ_ALERT] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    // pin pulls low when alert matches active-low, or idle in active-high
    st_nxt.od_oe_b = !(st_nxt.alert ^ st_nxt.conf[`TMA_CONF_POL]);
  end

  // state register, reset defaults
  // thresholds come up at their defaults so the pin works without a host
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r.cv <= TMA_CV_RUN;
      st_r.cnt <= '0;
      st_r.temp <= '0;
      st_r.tos <= `TMA_TOS_RST;
      st_r.hyst <= `TMA_HYST_RST;
      st_r.conf <= `TMA_CONF_RST;
      st_r.faults <= '0;
      st_r.alert <= 1'b0;
      st_r.look_low <= 1'b0;
      st_r.stat <= '0;
      st_r.mask <= '0;
      st_r.rdata <= '0;
      st_r.irq <= 1'b0;
      st_r.od_oe_b <= 1'b1;
      st_r.taddr <= '0;
      st_r.strap_done <= '0;
      st_r.adc_prev <= '0;
      st_r.adc_hold <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  // the data output stays low; only the enable moves the pin
  assign reg_rdata = st_r.rdata;
  assign target_addr = st_r.taddr;
  assign alert_od_out = 1'b0;
  assign alert_od_oe_b = st_r.od_oe_b;
  assign irq = st_r.irq;

endmodule

`default_nettype wire

/* sim/tma_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the register port and alert pin
module tma_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [6:0] target_addr,
  input wire logic alert_od_out,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // read answer shape
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0) else $error("stray read data");
  temp_low_a: assert property (
    reg_rd && reg_addr == 3'h0 |=> reg_rdata[6:0] == 7'h0)
    else $error("temp low bits set");
  unmap_zero_a: assert property (
    reg_rd && reg_addr == 3'h7 |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  // threshold write then read back
  tos_back_a: assert property (
    reg_wr && reg_addr == 3'h3 ##1 reg_rd && reg_addr == 3'h3
    |=> reg_rdata[15:7] == $past(reg_wdata[15:7], 2))
    else $error("alarm threshold lost");
  hyst_back_a: assert property (
    reg_wr && reg_addr == 3'h2 ##1 reg_rd && reg_addr == 3'h2
    |=> reg_rdata[15:7] == $past(reg_wdata[15:7], 2))
    else $error("release threshold lost");
  // pin, address and irq
  od_zero_a: assert property (
    alert_od_out == 1'b0) else $error("open drain drives high");
  taddr_hi_a: assert property (
    target_addr != 7'h0 |-> target_addr[6:3] == 4'h9)
    else $error("address upper bits wrong");
  mask_irq_a: assert property (
    reg_wr && reg_addr == 3'h5 && reg_wdata[1:0] == 2'b00 |=> ##1 !irq)
    else $error("masked irq still high");
  stat_clear_a: assert property (
    reg_rd && reg_addr == 3'h4 |=> !irq)
    else $error("irq stays after status read");
  taddr_hold_a: assert property (
    target_addr != 7'h0 |=> $stable(target_addr))
    else $error("target address moved");
  // main scenarios reached
  cover property (reg_wr && reg_addr == 3'h3 ##1 reg_rd);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
bind tma_top tma_chk i_tma_chk (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .target_addr, .alert_od_out, .irq);
`default_nettype wire

/* sim/tma_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host on the register port, one strobe per cycle
module tma_host (
  input wire logic clk_sys,
  output logic [2:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // one-cycle write, thresholds set by the host
  // the strobe stays up for a following write; rd or idle drops it
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
  endtask
  // release both strobes and let n edges pass
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  // one-cycle read, data taken in the answer cycle
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* sim/tma_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// bench: host model drives registers, bench drives samples
module tma_top_tb;
  localparam int CV = 16;
  logic clk_sys, rst_b, reg_wr, reg_rd, alert_od_out, alert_od_oe_b, irq;
  logic [2:0] reg_addr, straps;
  logic [15:0] reg_wdata, reg_rdata, rd_d;
  logic [8:0] adc_sample;
  logic [6:0] target_addr;
  logic [2:0] ra[4] = '{3'h3, 3'h2, 3'h1, 3'h7};
  logic [15:0] rv[4] = '{16'h5000, 16'h4b00, 16'h0, 16'h0};
  int n_errors, samples_checked, seed, tos_m, hyst_m;
  int exp_q[$];
  tma_top #(.CONV_CYCLES(CV)) i_tma_top (.clk_sys, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_sample,
    .addr_strap_bit0(straps[0]), .addr_strap_bit1(straps[1]),
    .addr_strap_bit2(straps[2]), .target_addr, .alert_od_out,
    .alert_od_oe_b, .irq);
  tma_host i_tma_host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    seed = 87;
    straps = 3'($random(seed));
    adc_sample = 9'h000;
    rst_b = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(target_addr, {4'h9, straps});
    for (int i = 0; i < 4; i++) begin
      i_tma_host.rd(ra[i], rd_d);
      check(rd_d, rv[i]);
    end
    $display("reset test end");
    repeat (4) begin
      tos_m = $random(seed) & 16'h7f80;
      hyst_m = $random(seed) & 16'h7f80;
      exp_q.push_back(tos_m);
      exp_q.push_back(hyst_m);
      i_tma_host.wr(3'h3, tos_m[15:0]);
      i_tma_host.rd(3'h3, rd_d);
      check(rd_d, 16'(exp_q.pop_front()));
      i_tma_host.wr(3'h2, hyst_m[15:0]);
      i_tma_host.rd(3'h2, rd_d);
      check(rd_d, 16'(exp_q.pop_front()));
    end
    $display("threshold test end");
    i_tma_host.wr(3'h3, 16'h3200);
    i_tma_host.wr(3'h2, 16'h2800);
    i_tma_host.wr(3'h5, 16'h0003);
    i_tma_host.wr(3'h1, 16'h0008);
    i_tma_host.rd(3'h1, rd_d);
    check(rd_d, 16'h0008);
    adc_sample <= 9'h070;
    repeat (CV + 4) @(posedge clk_sys);
    check(alert_od_oe_b, 1'b1);
    repeat (CV) @(posedge clk_sys);
    check(alert_od_oe_b, 1'b0);
    i_tma_host.wr(3'h1, 16'h000c);
    i_tma_host.idle(4);
    check(alert_od_oe_b, 1'b1);
    adc_sample <= 9'h040;
    repeat (3 * CV) @(posedge clk_sys);
    check(alert_od_oe_b, 1'b0);
    i_tma_host.wr(3'h1, 16'h0002);
    adc_sample <= 9'h070;
    i_tma_host.idle(2 * CV);
    check(alert_od_oe_b, 1'b0);
    check(irq, 1'b1);
    i_tma_host.rd(3'h4, rd_d);
    check(rd_d, 16'h0003);
    i_tma_host.rd(3'h0, rd_d);
    check(rd_d, 16'h3800);
    check(alert_od_oe_b, 1'b1);
    check(irq, 1'b0);
    repeat (CV + 4) @(posedge clk_sys);
    check(alert_od_oe_b, 1'b1);
    i_tma_host.wr(3'h5, 16'h0000);
    i_tma_host.idle(3);
    check(irq, 1'b0);
    $display("alert test end");
    // shutdown with a six-fault queue: no conversion may complete
    i_tma_host.wr(3'h1, 16'h0019);
    i_tma_host.rd(3'h4, rd_d);
    i_tma_host.idle(2 * CV);
    i_tma_host.rd(3'h4, rd_d);
    check(rd_d, 16'h0000);
    i_tma_host.rd(3'h1, rd_d);
    check(rd_d, 16'h0019);
    check(alert_od_oe_b, 1'b1);
    $display("shutdown test end");
    print_verdict();
  end
endmodule
`default_nettype wire
